/* irq_output_config_defines.vh */
// constants for the interrupt pin configuration and output stage
// What this block does
// - hold-off interval field in bits 31:24, units of 10 us, resets zero
// - writing zero disables hold-off, clears counter, forwards pending interrupts at once
// - a new non-zero interval length applies to every later interrupt
// - power management event bypasses the hold-off and reaches the pin directly
// - writing one to bit 14 restarts the interval; self-clearing; zero ignored
// - bit 13 reads one while an interval withholds interrupts, else zero
// - bit 12 shows the combined enabled interrupt line, ignoring pin enable, hold-off
// - bit 8 gates the pin; zero keeps pin inactive unless bit 1 routes the crystal clock; status untouched
// - bit 4 selects pin level: zero active low, one active high
// - in open-drain mode the level bit is ignored; pin is active low
// - bit 0 selects driver: zero open-drain, one push-pull; resets zero
// - bit 1 routes the crystal clock onto the pin for debug
// - level and driver bits survive the soft digital reset
// - combined line rises only for a source whose status and enable are set
`ifndef IRQ_OUTPUT_CONFIG_DEFINES_VH
`define IRQ_OUTPUT_CONFIG_DEFINES_VH

// ****************************************
// register addresses (byte addresses)
// ****************************************
`define PIN_CONFIG_ADDR 12'h054
`define EVENT_STATUS_ADDR 12'h060
`define EVENT_MASK_ADDR 12'h064

// ****************************************
// pin configuration fields
// ****************************************
`define HOLDOFF_MSB 31
`define HOLDOFF_LSB 24
`define HOLDOFF_CLEAR_BIT 14
`define HOLDOFF_FLAG_BIT 13
`define COMBINED_LINE_BIT 12
`define PIN_ENABLE_BIT 8
`define ACTIVE_LEVEL_BIT 4
`define CLOCK_SELECT_BIT 1
`define DRIVE_TYPE_BIT 0
`define HOLDOFF_RESET 8'h00
`define FLAG_RESET 1'b0

// ****************************************
// block event status and mask fields
// ****************************************
`define EVENT_WIDTH 3
`define EV_HOLDOFF_START 0
`define EV_HOLDOFF_END 1
`define EV_PIN_ASSERT 2
`define EVENT_RESET 3'h0

// ****************************************
// timing
// ****************************************
`define CLOCK_PERIOD_NS 40
`define HOLDOFF_UNIT_NS 10000
`define HOLDOFF_UNIT_CYCLES (`HOLDOFF_UNIT_NS / `CLOCK_PERIOD_NS)

`endif

/* pin_sync3.v */
// three-stage synchroniser with agreement filter for an outside level
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // asynchronous level in, filtered level out
  input wire asyncIn,
  output reg syncOut
);
  reg stage1;
  reg stage2;
  reg stage3;

  // stage1 feeds only stage2 to keep metastability contained
  always @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        syncOut <= stage3;
      end
    end
  end
endmodule
`default_nettype wire

/* holdoff_tick.v */
// prescaler giving one pulse per hold-off unit
`timescale 1ns/100ps
`default_nettype none
module holdoff_tick #(
  parameter CYCLES = 250,
  parameter CW = 8
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // restart aligns the first tick a full unit after an interval start
  input wire restart,
  output reg tick
);
  localparam [CW-1:0] LAST = CYCLES - 1;
  reg [CW-1:0] count;

  always @(posedge clock) begin
    if (!rst_n || restart) begin
      count <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* irq_output_config.v */
// interrupt pin configuration, hold-off and output driver stage
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "irq_output_config_defines.vh"
module irq_output_config #(
  parameter SOURCES = 8,
  parameter ADDR_WIDTH = 12,
  parameter UNIT_CYCLES = `HOLDOFF_UNIT_CYCLES
) (
  // clock and resets
  input wire clock,
  input wire rst_n,
  input wire softReset,
  // avalon-mm slave
  input wire [ADDR_WIDTH-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // interrupt sources from the status and enable registers
  input wire [SOURCES-1:0] sourceStatus,
  input wire [SOURCES-1:0] sourceEnable,
  input wire powerMgmtEvent,
  input wire powerMgmtEnable,
  // crystal clock for debug observation
  input wire xtalClock,
  // interrupt pin, enable low while driving
  output reg irqPinOut,
  output reg irqPinOe_n,
  // block event interrupt
  output reg eventIrq
);

  // ****************************************
  // states and helpers
  // ****************************************
  localparam [1:0] FORWARD = 2'b00;
  localparam [1:0] ASSERTED = 2'b01;
  localparam [1:0] HOLDOFF = 2'b10;

  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer i;
    begin
      mergeBytes = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          mergeBytes[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  function addrHit;
    input [ADDR_WIDTH-1:0] addr;
    input [11:0] target;
    begin
      addrHit = (addr == target[ADDR_WIDTH-1:0]);
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] holdoffInterval;
  reg pinEnable;
  reg pinActiveLevel;
  reg clockSelect;
  reg pushPull;
  reg [`EVENT_WIDTH-1:0] eventStatus;
  reg [`EVENT_WIDTH-1:0] eventMask;
  reg [1:0] state;
  reg [7:0] holdoffCount;
  reg pinAssertDly;

  reg [1:0] next_state;
  reg [7:0] next_holdoffCount;
  reg startInterval;
  reg next_irqPinOut;
  reg next_irqPinOe_n;
  reg [31:0] readValue;

  wire tick;
  wire xtalLevel;

  // ****************************************
  // combined interrupt line
  // ****************************************
  wire [SOURCES-1:0] gatedSource;
  genvar g;
  generate
    for (g = 0; g < SOURCES; g = g + 1) begin : gate
      assign gatedSource[g] = sourceStatus[g] & sourceEnable[g];
    end
  endgenerate

  wire sourceLine = |gatedSource;
  wire powerLine = powerMgmtEvent & powerMgmtEnable;
  wire combinedLine = sourceLine | powerLine;

  // ****************************************
  // bus decode
  // ****************************************
  // one wait state: waitrequest drops the cycle after a request shows
  wire takeWrite = write && !waitrequest;
  wire cfgWrite = takeWrite && addrHit(address, `PIN_CONFIG_ADDR);
  wire statusWrite = takeWrite && addrHit(address, `EVENT_STATUS_ADDR);
  wire maskWrite = takeWrite && addrHit(address, `EVENT_MASK_ADDR);

  // every stored field must sit in the old word so unselected lanes keep their value
  wire [31:0] cfgWord = {holdoffInterval, 15'h0000, pinEnable, 3'h0, pinActiveLevel, 2'h0,
                         clockSelect, pushPull};
  wire [31:0] cfgMerged = mergeBytes(cfgWord, writedata, byteenable);
  wire [7:0] writtenInterval = cfgMerged[`HOLDOFF_MSB:`HOLDOFF_LSB];
  wire intervalTouched = cfgWrite && byteenable[3];
  wire intervalToZero = intervalTouched && (writtenInterval == 8'h00);
  wire clearRequest = cfgWrite && byteenable[1] &&
                      writedata[`HOLDOFF_CLEAR_BIT];

  // the interval length that a clear-bit restart uses, including a same-write update
  wire [7:0] effectiveInterval = intervalTouched ? writtenInterval : holdoffInterval;

  // ****************************************
  // helpers
  // ****************************************
  holdoff_tick #(
    .CYCLES(UNIT_CYCLES),
    .CW(8)
  ) unitTick (
    .clock(clock),
    .rst_n(rst_n),
    .restart(startInterval | softReset),
    .tick(tick)
  );

  // sampling a clock this fast aliases; it is only a coarse debug view
  pin_sync3 xtalSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(xtalClock),
    .syncOut(xtalLevel)
  );

  // ****************************************
  // bus handshake and read data
  // ****************************************
  always @(posedge clock) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always @* begin
    readValue = 32'h0000_0000;
    if (addrHit(address, `PIN_CONFIG_ADDR)) begin
      readValue[`HOLDOFF_MSB:`HOLDOFF_LSB] = holdoffInterval;
      readValue[`HOLDOFF_FLAG_BIT] = (state == HOLDOFF);
      readValue[`COMBINED_LINE_BIT] = combinedLine;
      readValue[`PIN_ENABLE_BIT] = pinEnable;
      readValue[`ACTIVE_LEVEL_BIT] = pinActiveLevel;
      readValue[`CLOCK_SELECT_BIT] = clockSelect;
      readValue[`DRIVE_TYPE_BIT] = pushPull;
    end else if (addrHit(address, `EVENT_STATUS_ADDR)) begin
      readValue[`EVENT_WIDTH-1:0] = eventStatus;
    end else if (addrHit(address, `EVENT_MASK_ADDR)) begin
      readValue[`EVENT_WIDTH-1:0] = eventMask;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= readValue;
    end
  end

  // ****************************************
  // configuration register
  // ****************************************
  // the clear bit has no storage, so it always reads back zero
  always @(posedge clock) begin
    if (!rst_n) begin
      holdoffInterval <= `HOLDOFF_RESET;
      pinEnable <= `FLAG_RESET;
      clockSelect <= `FLAG_RESET;
      pinActiveLevel <= `FLAG_RESET;
      pushPull <= `FLAG_RESET;
    end else if (softReset) begin
      holdoffInterval <= `HOLDOFF_RESET;
      pinEnable <= `FLAG_RESET;
      clockSelect <= `FLAG_RESET;
    end else if (cfgWrite) begin
      holdoffInterval <= writtenInterval;
      pinEnable <= cfgMerged[`PIN_ENABLE_BIT];
      pinActiveLevel <= cfgMerged[`ACTIVE_LEVEL_BIT];
      clockSelect <= cfgMerged[`CLOCK_SELECT_BIT];
      pushPull <= cfgMerged[`DRIVE_TYPE_BIT];
    end
  end

  // ****************************************
  // hold-off state machine
  // ****************************************
  always @* begin
    next_state = state;
    next_holdoffCount = holdoffCount;
    startInterval = 1'b0;
    case (state)
      FORWARD: begin
        if (sourceLine) begin
          next_state = ASSERTED;
        end
      end
      ASSERTED: begin
        if (!sourceLine && holdoffInterval != 8'h00) begin
          next_state = HOLDOFF;
          next_holdoffCount = holdoffInterval;
          startInterval = 1'b1;
        end else if (!sourceLine) begin
          next_state = FORWARD;
        end
      end
      HOLDOFF: begin
        if (tick) begin
          if (holdoffCount <= 8'h01) begin
            next_state = FORWARD;
            next_holdoffCount = 8'h00;
          end else begin
            next_holdoffCount = holdoffCount - 8'h01;
          end
        end
      end
      default: begin
        next_state = FORWARD;
        next_holdoffCount = 8'h00;
      end
    endcase
    if (clearRequest && effectiveInterval != 8'h00) begin
      next_state = HOLDOFF;
      next_holdoffCount = effectiveInterval;
      startInterval = 1'b1;
    end
    if (intervalToZero) begin
      next_state = FORWARD;
      next_holdoffCount = 8'h00;
      startInterval = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      state <= FORWARD;
      holdoffCount <= 8'h00;
    end else begin
      state <= next_state;
      holdoffCount <= next_holdoffCount;
    end
  end

  // ****************************************
  // pin driver
  // ****************************************
  wire withheld = (state == HOLDOFF);
  wire forwardedLine = (sourceLine && !withheld) || powerLine;
  wire pinAssert = pinEnable && forwardedLine;

  always @* begin
    next_irqPinOut = 1'b0;
    next_irqPinOe_n = 1'b1;
    if (pushPull) begin
      next_irqPinOe_n = 1'b0;
      if (clockSelect) begin
        next_irqPinOut = xtalLevel;
      end else begin
        next_irqPinOut = pinActiveLevel ? pinAssert : !pinAssert;
      end
    end else begin
      // open drain only ever pulls low, so the level bit cannot apply
      next_irqPinOut = 1'b0;
      if (clockSelect) begin
        next_irqPinOe_n = xtalLevel;
      end else begin
        next_irqPinOe_n = !pinAssert;
      end
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      irqPinOut <= 1'b0;
      irqPinOe_n <= 1'b1;
      pinAssertDly <= 1'b0;
    end else begin
      irqPinOut <= next_irqPinOut;
      irqPinOe_n <= next_irqPinOe_n;
      pinAssertDly <= pinAssert;
    end
  end

  // ****************************************
  // block events
  // ****************************************
  wire [`EVENT_WIDTH-1:0] eventSet;
  assign eventSet[`EV_HOLDOFF_START] = startInterval;
  assign eventSet[`EV_HOLDOFF_END] = (state == HOLDOFF) && (next_state == FORWARD);
  assign eventSet[`EV_PIN_ASSERT] = pinAssert && !pinAssertDly;

  wire [31:0] clearWord = mergeBytes(32'h0000_0000, writedata, byteenable);
  wire [`EVENT_WIDTH-1:0] eventClear =
    statusWrite ? clearWord[`EVENT_WIDTH-1:0] : {`EVENT_WIDTH{1'b0}};
  // a set in the same cycle as its clear wins so no event is lost
  wire [`EVENT_WIDTH-1:0] next_eventStatus = (eventStatus & ~eventClear) | eventSet;
  wire [31:0] maskMerged = mergeBytes({29'h0000_0000, eventMask}, writedata, byteenable);
  wire [`EVENT_WIDTH-1:0] next_eventMask =
    maskWrite ? maskMerged[`EVENT_WIDTH-1:0] : eventMask;

  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      eventStatus <= `EVENT_RESET;
      eventMask <= `EVENT_RESET;
      eventIrq <= 1'b0;
    end else begin
      eventStatus <= next_eventStatus;
      eventMask <= next_eventMask;
      eventIrq <= |(next_eventStatus & next_eventMask);
    end
  end

endmodule
`default_nettype wire

/* irq_output_config_sva.sv */
// checker for the interrupt pin configuration block
`timescale 1ns/100ps
`default_nettype none
`include "irq_output_config_defines.vh"
module irq_output_config_sva #(
  parameter SOURCES = 8,
  parameter ADDR_WIDTH = 12,
  parameter UNIT_CYCLES = 250
) (
  // clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  // avalon-mm
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // sources
  input wire logic [SOURCES-1:0] sourceStatus,
  input wire logic [SOURCES-1:0] sourceEnable,
  input wire logic powerMgmtEvent,
  input wire logic powerMgmtEnable,
  input wire logic xtalClock,
  // pin and event
  input wire logic irqPinOut,
  input wire logic irqPinOe_n,
  input wire logic eventIrq
);
  // ****************
  // config shadow
  // ****************
  // pin checks wait one cycle after a config change, as the pin register lags it
  reg [7:0] shInt;
  reg shEn, shLvl, shClk, shPp, pmD;
  reg [3:0] cfgD;
  wire [3:0] cfg = {shEn, shLvl, shClk, shPp};
  wire steady = cfg == cfgD;
  wire comb = |(sourceStatus & sourceEnable) | (powerMgmtEvent & powerMgmtEnable);
  wire actv = !irqPinOe_n && (shPp ? irqPinOut == shLvl : !irqPinOut);
  wire inact = shPp ? !irqPinOe_n && irqPinOut == !shLvl : irqPinOe_n && !irqPinOut;
  wire wrCfg = write && !waitrequest && address == `PIN_CONFIG_ADDR;
  always @(posedge clock) begin
    cfgD <= rst_n ? cfg : 4'h0;
    pmD <= powerMgmtEvent & powerMgmtEnable;
    if (!rst_n || softReset) begin
      shInt <= 8'h00;
      shEn <= 1'b0;
      shClk <= 1'b0;
      if (!rst_n) begin
        shLvl <= 1'b0;
        shPp <= 1'b0;
      end
    end else if (wrCfg) begin
      if (byteenable[3]) shInt <= writedata[31:24];
      if (byteenable[1]) shEn <= writedata[8];
      if (byteenable[0]) begin
        shLvl <= writedata[4];
        shClk <= writedata[1];
        shPp <= writedata[0];
      end
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rdAck;
    read && !waitrequest;
  endsequence
  sequence rdCfg;
    rdAck ##0 address == `PIN_CONFIG_ADDR;
  endsequence
  AST_RESET: assert property (disable iff (1'b0) !rst_n |=> waitrequest && irqPinOe_n
    && !irqPinOut && !eventIrq) else $error("outputs not at reset values");
  AST_WAIT_ONE: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_CAUSE: assert property ($fell(waitrequest) |-> $past(read) || $past(write))
    else $error("waitrequest fell without a request");
  AST_UNMAPPED: assert property (rdAck ##0 (address != `PIN_CONFIG_ADDR && address !=
    `EVENT_STATUS_ADDR && address != `EVENT_MASK_ADDR) |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RSVD_ZERO: assert property (rdCfg |-> (readdata & 32'h00FF_CEEC) == 32'h0000_0000)
    else $error("reserved or clear bit reads one");
  AST_CFG_ECHO: assert property (rdCfg |-> {readdata[31:24], readdata[8], readdata[4],
    readdata[1:0]} == {shInt, cfg}) else $error("config readback wrong");
  AST_COMBINED: assert property (rdCfg |-> readdata[12] == $past(comb))
    else $error("combined line bit wrong");
  AST_FLAG_ZERO: assert property (rdCfg ##0 shInt == 8'h00 |-> !readdata[13])
    else $error("hold-off flag set with zero interval");
  AST_PIN_OFF: assert property (steady && !shEn && !shClk |-> inact)
    else $error("pin active while disabled");
  AST_PP_DRIVE: assert property (steady && shPp |-> !irqPinOe_n)
    else $error("push-pull pin not driven");
  AST_OD_LOW: assert property (steady && !shPp |-> !irqPinOut)
    else $error("open-drain pin driven high");
  AST_PM_BYPASS: assert property (steady && shEn && !shClk && pmD |-> actv)
    else $error("power event withheld from pin");
endmodule
bind irq_output_config irq_output_config_sva #(.SOURCES(SOURCES), .ADDR_WIDTH(ADDR_WIDTH),
  .UNIT_CYCLES(UNIT_CYCLES)) sva (.clock(clock), .rst_n(rst_n), .softReset(softReset),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .sourceStatus(sourceStatus), .sourceEnable(sourceEnable), .powerMgmtEvent(powerMgmtEvent),
  .powerMgmtEnable(powerMgmtEnable), .xtalClock(xtalClock), .irqPinOut(irqPinOut),
  .irqPinOe_n(irqPinOe_n), .eventIrq(eventIrq));
`default_nettype wire

/* host_irq_input.sv */
// host-side interrupt input with a pull-up on the shared line
`timescale 1ns/100ps
`default_nettype none
module host_irq_input (
  // pin from the device
  input wire logic irqPinOut,
  input wire logic irqPinOe_n,
  // level the host sees
  output logic pinLevel
);
  // a released line floats to the pull-up, so wired-or sharing reads high
  assign pinLevel = irqPinOe_n ? 1'b1 : irqPinOut;
endmodule
`default_nettype wire

/* test_irq_output_config.sv */
// testbench for the interrupt pin configuration block
`timescale 1ns/100ps
`default_nettype none
`include "irq_output_config_defines.vh"
module test_irq_output_config;
  localparam [11:0] CF = `PIN_CONFIG_ADDR, ST = `EVENT_STATUS_ADDR, MK = `EVENT_MASK_ADDR;
  reg clock = 1'b0, rst_n = 1'b0, softReset = 1'b0, read = 1'b0, write = 1'b0;
  reg powerMgmtEvent = 1'b0, powerMgmtEnable = 1'b0, xtalClock = 1'b0;
  reg [11:0] address = 12'h000;
  reg [31:0] writedata = 32'h0000_0000, d;
  reg [3:0] byteenable = 4'h0;
  reg [7:0] sourceStatus = 8'h00, sourceEnable = 8'h00;
  wire [31:0] readdata;
  wire waitrequest, irqPinOut, irqPinOe_n, eventIrq, pinLevel;
  integer mismatches = 0, compares = 0, cycles = 0, i;
  // ****************
  // design and host
  // ****************
  // a short unit keeps the hold-off intervals to a few dozen cycles
  irq_output_config #(.UNIT_CYCLES(4)) dut (.clock(clock), .rst_n(rst_n),
    .softReset(softReset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sourceStatus(sourceStatus), .sourceEnable(sourceEnable),
    .powerMgmtEvent(powerMgmtEvent), .powerMgmtEnable(powerMgmtEnable),
    .xtalClock(xtalClock), .irqPinOut(irqPinOut), .irqPinOe_n(irqPinOe_n),
    .eventIrq(eventIrq));
  host_irq_input host (.irqPinOut(irqPinOut), .irqPinOe_n(irqPinOe_n), .pinLevel(pinLevel));
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  // ****************
  // tasks
  // ****************
  task cyc(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task chk1(input s, input e);
    chk({31'h0000_0000, s}, {31'h0000_0000, e});
  endtask
  task wr(input [11:0] a, input [31:0] v, input [3:0] be);
    @(posedge clock);
    address <= a;
    writedata <= v;
    byteenable <= be;
    write <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    write <= 1'b0;
  endtask
  task rd(input [11:0] a);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    d = readdata;
    read <= 1'b0;
  endtask
  task results;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    rd(CF);
    chk(d, 32'h0000_0000);
    wr(12'h100, 32'hFFFF_FFFF, 4'hF);
    rd(12'h100);
    chk(d, 32'h0000_0000);
    wr(CF, 32'h0800_0111, 4'hF);
    sourceEnable <= 8'h01;
    sourceStatus <= 8'h01;
    cyc(3);
    chk1(pinLevel, 1'b1);
    sourceStatus <= 8'h00;
    cyc(3);
    chk1(pinLevel, 1'b0);
    rd(CF);
    chk(d & 32'h0000_2000, 32'h0000_2000);
    sourceStatus <= 8'h01;
    cyc(3);
    chk1(pinLevel, 1'b0);
    rd(CF);
    chk(d & 32'h0000_1000, 32'h0000_1000);
    powerMgmtEnable <= 1'b1;
    powerMgmtEvent <= 1'b1;
    cyc(3);
    chk1(pinLevel, 1'b1);
    powerMgmtEvent <= 1'b0;
    cyc(3);
    chk1(pinLevel, 1'b0);
    wr(CF, 32'h0000_4100, 4'h2);
    cyc(22);
    rd(CF);
    chk(d & 32'h0000_2000, 32'h0000_2000);
    wr(CF, 32'h0000_0000, 4'h8);
    cyc(3);
    chk1(pinLevel, 1'b1);
    rd(CF);
    chk(d & 32'h0000_2000, 32'h0000_0000);
    wr(CF, 32'h0200_0000, 4'h8);
    sourceStatus <= 8'h00;
    cyc(3);
    rd(CF);
    chk(d & 32'h0000_2000, 32'h0000_2000);
    cyc(12);
    rd(CF);
    chk(d, 32'h0200_0111);
    rd(ST);
    chk(d, 32'h0000_0007);
    chk1(eventIrq, 1'b0);
    wr(MK, 32'h0000_0001, 4'hF);
    cyc(2);
    chk1(eventIrq, 1'b1);
    wr(ST, 32'h0000_0007, 4'hF);
    cyc(2);
    chk1(eventIrq, 1'b0);
    rd(ST);
    chk(d, 32'h0000_0000);
    wr(CF, 32'h0000_0011, 4'hF);
    sourceStatus <= 8'h01;
    cyc(3);
    chk1(pinLevel, 1'b0);
    rd(CF);
    chk(d & 32'h0000_1000, 32'h0000_1000);
    sourceEnable <= 8'h00;
    cyc(3);
    rd(CF);
    chk(d & 32'h0000_1000, 32'h0000_0000);
    sourceEnable <= 8'h01;
    wr(CF, 32'h0000_0110, 4'hF);
    cyc(3);
    chk1(pinLevel, 1'b0);
    sourceStatus <= 8'h00;
    cyc(3);
    chk1(pinLevel, 1'b1);
    wr(CF, 32'h0000_0101, 4'hF);
    cyc(3);
    chk1(pinLevel, 1'b1);
    sourceStatus <= 8'h01;
    cyc(3);
    chk1(pinLevel, 1'b0);
    sourceStatus <= 8'h00;
    wr(CF, 32'h0000_0111, 4'hF);
    wr(CF, 32'h0000_0113, 4'hF);
    for (i = 0; i < 4; i = i + 1) begin
      xtalClock <= i[0];
      cyc(8);
      chk1(pinLevel, i[0]);
    end
    wr(CF, 32'h0500_0111, 4'hF);
    softReset <= 1'b1;
    cyc(1);
    softReset <= 1'b0;
    rd(CF);
    chk(d, 32'h0000_0011);
    results;
  end
endmodule
`default_nettype wire
